//--- logic/rmp_pkg.sv
// Constants and types for the reset and mirror park control block
package rmp_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned FAST_PARK_US = 40;
  localparam int unsigned NORMAL_PARK_MS = 20;
  localparam int unsigned CFG_QUIET_MS = 500;
  localparam int unsigned FAST_PARK_CYC = FAST_PARK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned NORMAL_PARK_CYC = NORMAL_PARK_MS * (CLK_HZ / 1000);
  localparam int unsigned CFG_QUIET_CYC = CFG_QUIET_MS * (CLK_HZ / 1000);
  localparam int unsigned INIT_CYC_DEF = 64;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned GP_W = 15;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_HOLD = 6'h01,
    ST_INIT = 6'h02,
    ST_RUN = 6'h04,
    ST_NPARK = 6'h08,
    ST_FPARK = 6'h10,
    ST_PARKED = 6'h20
  } rmp_state_type;
endpackage

//--- logic/rmp_io_if.sv
// Grouped output enables carried from the sequencer to the pad gate
interface rmp_io_if;
  logic pads_live;
  logic mirror_live;
  modport ctl (output pads_live, output mirror_live);
  modport pad (input pads_live, input mirror_live);
endinterface

//--- logic/rmp_pad_gate.sv
// Pad gating: floats or forces outputs low while the block is held
module rmp_pad_gate
  import rmp_pkg::*;
(
  rmp_io_if.pad io,
  input wire logic [GP_W-1:0] gp_out_i,
  input wire logic [GP_W-1:0] gp_oe_i,
  input wire logic [5:0] ser_out_i,
  input wire logic [1:0] sync_i,
  input wire logic [1:0] led_i,
  output logic [GP_W-1:0] general_pins_19_to_5_o,
  output logic [GP_W-1:0] general_pins_19_to_5_oe_o,
  output logic [5:0] ser_o,
  output logic [5:0] ser_oe_o,
  output logic [1:0] sync_o,
  output logic [1:0] sync_oe_o,
  output logic [1:0] led_o
);
  // ----------------------------------------
  // Per pin gating
  // ----------------------------------------
  for (genvar g = 0; g < GP_W; g++) begin : g_gp
    assign general_pins_19_to_5_o[g] = io.pads_live & gp_out_i[g];
    assign general_pins_19_to_5_oe_o[g] = io.pads_live & gp_oe_i[g];
  end
  assign ser_o = io.pads_live ? ser_out_i : 6'h00;
  assign ser_oe_o = {6{io.pads_live}};
  assign sync_o = io.pads_live ? sync_i : 2'h0;
  assign sync_oe_o = {2{io.pads_live}};
  assign led_o = io.mirror_live ? led_i : 2'h0;
endmodule

//--- logic/rmp_top.sv
// Reset and mirror park sequencer top level
module rmp_top
  import rmp_pkg::*;
#(
  parameter int unsigned INIT_CYC = INIT_CYC_DEF,
  parameter int unsigned FAST_CYC = FAST_PARK_CYC,
  parameter int unsigned NORMAL_CYC = NORMAL_PARK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_on_reset_low_i,
  input wire logic fast_mirror_stop_low_i,
  input wire logic normal_mirror_stop_request_low_i,
  input wire logic service_req_i,
  input wire logic [1:0] light_source_req_i,
  input wire logic [1:0] sync_req_i,
  input wire logic [5:0] serial_req_i,
  input wire logic [GP_W-1:0] gp_out_req_i,
  input wire logic [GP_W-1:0] gp_oe_req_i,
  output logic light_source_select_0_o,
  output logic light_source_select_1_o,
  output logic mirror_driver_enable_reset_low_o,
  output logic [1:0] sync_output_o,
  output logic [1:0] sync_output_oe_o,
  output logic [5:0] serial_o,
  output logic [5:0] serial_oe_o,
  output logic [GP_W-1:0] general_pins_19_to_5_o,
  output logic [GP_W-1:0] general_pins_19_to_5_oe_o,
  output logic host_irq_o,
  output logic host_irq_oe_o,
  output logic init_done_o,
  output logic parked_o
);
  rmp_state_type state_r;
  rmp_state_type state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [1:0] rst_sync_r;
  logic rst_seen_r;
  logic hold;
  logic rise;
  logic [1:0] led_r;
  logic [1:0] sync_r;
  logic [5:0] ser_r;
  logic [GP_W-1:0] gp_r;
  logic [GP_W-1:0] gpoe_r;
  logic irq_r;
  logic [1:0] led_w;
  rmp_io_if io ();

  // ----------------------------------------
  // Reset input synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_sync_r <= 2'h0;
      rst_seen_r <= 1'b0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], power_on_reset_low_i};
      rst_seen_r <= rst_sync_r[1];
    end
  end
  assign hold = ~rst_sync_r[1];
  assign rise = rst_sync_r[1] & ~rst_seen_r;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD: begin
        if (rise) begin
          state_nxt = ST_INIT;
        end
      end
      ST_INIT: begin
        if (!fast_mirror_stop_low_i) begin
          state_nxt = ST_FPARK;
        end else if (cnt_r == CNT_W'(INIT_CYC - 1)) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!fast_mirror_stop_low_i) begin
          state_nxt = ST_FPARK;
        end else if (!normal_mirror_stop_request_low_i) begin
          state_nxt = ST_NPARK;
        end
      end
      ST_NPARK: begin
        if (!fast_mirror_stop_low_i) begin
          state_nxt = ST_FPARK;
        end else if (cnt_r == CNT_W'(NORMAL_CYC - 1)) begin
          state_nxt = ST_PARKED;
        end
      end
      ST_FPARK: begin
        if (cnt_r == CNT_W'(FAST_CYC - 1)) begin
          state_nxt = ST_PARKED;
        end
      end
      ST_PARKED: begin
        if (fast_mirror_stop_low_i && normal_mirror_stop_request_low_i) begin
          state_nxt = ST_INIT;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
    if (hold) begin
      state_nxt = ST_HOLD;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      led_r <= 2'h0;
      sync_r <= 2'h0;
      ser_r <= 6'h00;
      gp_r <= '0;
      gpoe_r <= '0;
      irq_r <= 1'b0;
    end else begin
      led_r <= light_source_req_i;
      sync_r <= sync_req_i;
      ser_r <= serial_req_i;
      gp_r <= gp_out_req_i;
      gpoe_r <= gp_oe_req_i;
      irq_r <= (state_r == ST_INIT) | service_req_i;
    end
  end

  assign io.pads_live = ~hold && (state_r != ST_HOLD);
  assign io.mirror_live = ~hold && (state_r == ST_RUN);

  rmp_pad_gate u_gate (
    .io(io.pad),
    .gp_out_i(gp_r),
    .gp_oe_i(gpoe_r),
    .ser_out_i(ser_r),
    .sync_i(sync_r),
    .led_i(led_r),
    .general_pins_19_to_5_o(general_pins_19_to_5_o),
    .general_pins_19_to_5_oe_o(general_pins_19_to_5_oe_o),
    .ser_o(serial_o),
    .ser_oe_o(serial_oe_o),
    .sync_o(sync_output_o),
    .sync_oe_o(sync_output_oe_o),
    .led_o(led_w)
  );
  assign light_source_select_0_o = led_w[0];
  assign light_source_select_1_o = led_w[1];
  assign mirror_driver_enable_reset_low_o = io.mirror_live;
  assign host_irq_o = irq_r & io.pads_live;
  assign host_irq_oe_o = io.pads_live;
  assign init_done_o = (state_r == ST_RUN);
  assign parked_o = (state_r == ST_PARKED);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_hold_quiet;
    @(posedge clk_i) disable iff (rst_i)
    hold |-> (serial_oe_o == 6'h00 && sync_output_oe_o == 2'h0
      && general_pins_19_to_5_oe_o == '0 && !host_irq_oe_o);
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("pads driven");

  property p_hold_low;
    @(posedge clk_i) disable iff (rst_i)
    hold |-> !mirror_driver_enable_reset_low_o && !light_source_select_0_o
      && !light_source_select_1_o;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("not low in reset");

  property p_start;
    @(posedge clk_i) disable iff (rst_i)
    (rise && state_r == ST_HOLD) |=> state_r == ST_INIT;
  endproperty
  a_start: assert property (p_start) else $error("no init start");

  property p_fast_only;
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ST_RUN && !fast_mirror_stop_low_i && !hold)
      |=> state_r == ST_FPARK;
  endproperty
  a_fast_only: assert property (p_fast_only) else $error("run w/o fast hi");

  property p_switch;
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ST_NPARK && !fast_mirror_stop_low_i && !hold)
      |=> state_r == ST_FPARK;
  endproperty
  a_switch: assert property (p_switch) else $error("no fast switch");

  property p_fast_len;
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ST_FPARK) |-> cnt_r < CNT_W'(FAST_CYC);
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("fast park long");

  property p_norm_len;
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ST_NPARK) |-> cnt_r < CNT_W'(NORMAL_CYC);
  endproperty
  a_norm_len: assert property (p_norm_len) else $error("park too long");

  property p_sync_hold;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_sync_r[1]) |=> state_r == ST_HOLD;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("live in reset");

  property p_idle_inactive;
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ST_HOLD) |-> !init_done_o && !host_irq_o;
  endproperty
  a_idle_inactive: assert property (p_idle_inactive) else $error("active");
endmodule

//--- testbench/rmp_pmic_model.sv
// Model of the power IC and host driving reset and the stop inputs
module rmp_pmic_model #(
  parameter int unsigned HOLD_MIN = 8
) (
  input wire logic clk_i,
  output logic por_low_o,
  output logic fast_low_o,
  output logic normal_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_cnt = 0;
  initial begin
    por_low_o = 1'b0;
    fast_low_o = 1'b0;
    normal_low_o = 1'b1;
  end
  always @(posedge clk_i) begin
    low_cnt <= fast_low_o ? 0 : low_cnt + 1;
  end
  // No configuration traffic is produced here
  task automatic power_up();
    @(posedge clk_i) fast_low_o <= 1'b1;
    @(posedge clk_i) por_low_o <= 1'b1;
  endtask
  task automatic reset_hold();
    @(posedge clk_i) por_low_o <= 1'b0;
  endtask
  task automatic fast_stop();
    @(posedge clk_i) fast_low_o <= 1'b0;
  endtask
  task automatic normal_stop();
    @(posedge clk_i) normal_low_o <= 1'b0;
  endtask
  task automatic release_stops();
    while (!fast_low_o && low_cnt < HOLD_MIN) @(posedge clk_i);
    @(posedge clk_i) begin
      fast_low_o <= 1'b1;
      normal_low_o <= 1'b1;
    end
  endtask
endmodule

//--- testbench/rmp_top_tb.sv
// Self-checking bench for the reset and mirror park sequencer
module rmp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rmp_pkg::*;
  localparam int INIT_N = 8;
  localparam int FAST_N = 8;
  localparam int NORM_N = 40;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_low, fast_low, norm_low;
  logic svc = 1'b0;
  logic [1:0] ls_req = 2'h1;
  logic [1:0] sy_req = 2'h2;
  logic [5:0] serq = 6'h2d;
  logic [GP_W-1:0] gpd = 15'h2a5a;
  logic [GP_W-1:0] gpq = 15'h7fff;
  logic ls0, ls1, men, irq, irq_oe, done, parked;
  logic [1:0] so, so_oe;
  logic [5:0] ser, ser_oe;
  logic [GP_W-1:0] gp, gp_oe;
  logic [52:0] all_o;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  assign all_o = {ls1, ls0, so, so_oe, ser, ser_oe, gp, gp_oe, irq_oe, irq,
                  men, done, parked};
  always #10 clk_i = ~clk_i;
  rmp_pmic_model #(.HOLD_MIN(FAST_N)) i_pmic (.clk_i(clk_i),
    .por_low_o(por_low), .fast_low_o(fast_low), .normal_low_o(norm_low));
  rmp_top #(.INIT_CYC(INIT_N), .FAST_CYC(FAST_N), .NORMAL_CYC(NORM_N)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .power_on_reset_low_i(por_low),
    .fast_mirror_stop_low_i(fast_low),
    .normal_mirror_stop_request_low_i(norm_low), .service_req_i(svc),
    .light_source_req_i(ls_req), .sync_req_i(sy_req), .serial_req_i(serq),
    .gp_out_req_i(gpd), .gp_oe_req_i(gpq), .light_source_select_0_o(ls0),
    .light_source_select_1_o(ls1), .mirror_driver_enable_reset_low_o(men),
    .sync_output_o(so), .sync_output_oe_o(so_oe), .serial_o(ser),
    .serial_oe_o(ser_oe), .general_pins_19_to_5_o(gp),
    .general_pins_19_to_5_oe_o(gp_oe), .host_irq_o(irq),
    .host_irq_oe_o(irq_oe), .init_done_o(done), .parked_o(parked));
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      $display("unexpected cycles: expected below %0d, seen %0d", 3000, cyc);
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [52:0] e,
                     input logic [52:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic in_rng(input string nm, input int lo, input int hi,
                        input int n);
    checks_done++;
    if (n < lo || n > hi) begin
      err_total++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, hi, n);
    end
  endtask
  task automatic wait_bit(input int idx, output int n);
    n = 0;
    while (all_o[idx] !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask
  task automatic t_hold();
    repeat (3) @(posedge clk_i);
    #1;
    chk("held outputs", '0, all_o);
    $display("test hold done");
  endtask
  task automatic t_init();
    int n;
    logic [52:0] run_exp;
    i_pmic.power_up();
    wait_bit(3, n);
    in_rng("init irq delay", 2, 5, n);
    chk("done in init", '0, done);
    wait_bit(1, n);
    in_rng("init length", INIT_N - 2, INIT_N + 1, n);
    @(posedge clk_i);
    #1;
    run_exp = {1'b0, 1'b1, 2'h2, 2'h3, 6'h2d, 6'h3f, 15'h2a5a, 15'h7fff,
               1'b1, 4'h6};
    chk("run outputs", run_exp, all_o);
    @(posedge clk_i) svc <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("service irq", 1'b1, irq);
    @(posedge clk_i) svc <= 1'b0;
    $display("test init done");
  endtask
  task automatic t_park(input bit normal, input bit fast);
    int n;
    if (normal) i_pmic.normal_stop();
    if (normal && fast) repeat (4) @(posedge clk_i);
    if (fast) i_pmic.fast_stop();
    wait_bit(0, n);
    if (fast) in_rng("fast park", FAST_N, FAST_N + 3, n);
    else in_rng("normal park", NORM_N, NORM_N + 3, n);
    chk("parked state", 4'h1, all_o[3:0]);
    chk("parked lights", 2'h0, all_o[52:51]);
    i_pmic.release_stops();
    wait_bit(1, n);
    in_rng("restart", INIT_N, INIT_N + 3, n);
    $display("test park done");
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_hold();
    t_init();
    t_park(1'b1, 1'b0);
    t_park(1'b1, 1'b1);
    t_park(1'b0, 1'b1);
    i_pmic.reset_hold();
    t_hold();
    t_init();
    final_report();
  end
endmodule
